// File: alus_defs.vh
// Constants for the eight-bit subtract, logic and compare datapath slice
`ifndef ALUS_DEFS_VH
`define ALUS_DEFS_VH

// ---------------------------------------------------------------------------
// Operation codes (op_sel)
// ---------------------------------------------------------------------------
`define ALUS_OP_SUB 3'h0
`define ALUS_OP_SUBC 3'h1
`define ALUS_OP_OR 3'h2
`define ALUS_OP_XOR 3'h3
`define ALUS_OP_CMP 3'h4

// ---------------------------------------------------------------------------
// Operand forms (form_sel)
// ---------------------------------------------------------------------------
`define ALUS_FM_A_IMM 3'h0
`define ALUS_FM_SADDR_IMM 3'h1
`define ALUS_FM_A_REG 3'h2
`define ALUS_FM_REG_A 3'h3
`define ALUS_FM_A_SADDR 3'h4
`define ALUS_FM_A_ABS 3'h5
`define ALUS_FM_A_PTR 3'h6
`define ALUS_FM_A_PTR_IDX 3'h7

// ---------------------------------------------------------------------------
// Index select for pointer-indexed form (idx_sel)
// ---------------------------------------------------------------------------
`define ALUS_IDX_DISP 2'h0
`define ALUS_IDX_B 2'h1
`define ALUS_IDX_C 2'h2

// ---------------------------------------------------------------------------
// Destination codes (dest)
// ---------------------------------------------------------------------------
`define ALUS_DST_NONE 2'h0
`define ALUS_DST_ACC 2'h1
`define ALUS_DST_REG 2'h2
`define ALUS_DST_MEM 2'h3

// ---------------------------------------------------------------------------
// Page of the short direct address
// ---------------------------------------------------------------------------
`define ALUS_SADDR_PAGE 8'hFE

// ---------------------------------------------------------------------------
// Instruction lengths in bytes
// ---------------------------------------------------------------------------
`define ALUS_LEN_1 2'h1
`define ALUS_LEN_2 2'h2
`define ALUS_LEN_3 2'h3

// ---------------------------------------------------------------------------
// Execution cycle counts (fast RAM or no data access / other memory)
// ---------------------------------------------------------------------------
`define ALUS_CYC_4 4'h4
`define ALUS_CYC_5 4'h5
`define ALUS_CYC_6 4'h6
`define ALUS_CYC_8 4'h8
`define ALUS_CYC_9 4'h9

`endif

// File: alus_timing_rom.v
// Length and cycle lookup for each operand form
`include "alus_defs.vh"
`default_nettype none

module alus_timing_rom (
    input wire sys_clk,
    input wire rst_n,
    input wire clk_en,
    input wire load,
    input wire [2:0] form,
    input wire slow_mem,
    output reg [1:0] length,
    output reg [3:0] cycles
);

    // -----------------------------------------------------------------------
    // Registered lookup
    // -----------------------------------------------------------------------
    reg [1:0] next_length;
    reg [3:0] next_cycles;

    always @* begin
        next_length = `ALUS_LEN_2;
        next_cycles = `ALUS_CYC_4;
        case (form)
            `ALUS_FM_A_IMM, `ALUS_FM_A_REG, `ALUS_FM_REG_A: begin
                next_length = `ALUS_LEN_2;
                next_cycles = `ALUS_CYC_4;
            end
            `ALUS_FM_SADDR_IMM: begin
                next_length = `ALUS_LEN_3;
                next_cycles = slow_mem ? `ALUS_CYC_8 : `ALUS_CYC_6;
            end
            `ALUS_FM_A_SADDR: begin
                next_length = `ALUS_LEN_2;
                next_cycles = slow_mem ? `ALUS_CYC_5 : `ALUS_CYC_4;
            end
            `ALUS_FM_A_ABS: begin
                next_length = `ALUS_LEN_3;
                next_cycles = slow_mem ? `ALUS_CYC_9 : `ALUS_CYC_8;
            end
            `ALUS_FM_A_PTR: begin
                next_length = `ALUS_LEN_1;
                next_cycles = slow_mem ? `ALUS_CYC_5 : `ALUS_CYC_4;
            end
            default: begin
                next_length = `ALUS_LEN_2;
                next_cycles = slow_mem ? `ALUS_CYC_9 : `ALUS_CYC_8;
            end
        endcase
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            length <= 2'h0;
            cycles <= 4'h0;
        end else if (clk_en && load) begin
            length <= next_length;
            cycles <= next_cycles;
        end
    end

endmodule // alus_timing_rom

`default_nettype wire

// File: alus_datapath.v
// Eight-bit subtract, subtract-with-borrow, OR, XOR and compare datapath
`include "alus_defs.vh"
`default_nettype none

// Overview of operation
// - A minus register into A, borrow to carry; 2 bytes, 4 cycles.
// - Register minus A into register, borrow to carry; 2 bytes, 4 cycles.
// - Short-direct byte minus immediate back to memory; 3 bytes, 6 or 8.
// - A minus absolute-address byte into A; 3 bytes, 8 or 9 cycles.
// - A minus byte at pointer pair into A; 1 byte, 4 or 5.
// - A minus byte at pointer plus displacement; 2 bytes, 8 or 9.
// - A minus byte at pointer plus B or C; 2 bytes, 8 or 9.
// - A minus immediate minus carry into A; 2 bytes, 4 cycles.
// - Short-direct byte minus immediate minus carry to memory; 3 bytes, 6 or 8.
// - A OR immediate into A, only zero flag changes; 2 bytes, 4.
// - Short-direct byte OR immediate back to memory; 3 bytes, 6 or 8.
// - OR of A and register either way into first operand; zero flag only.
// - A OR byte at pointer plus displacement into A; 2 bytes, 8 or 9.
// - Short-direct byte XOR immediate to memory, zero flag only; 6 or 8.
// - A XOR absolute-address byte into A; 3 bytes, 8 or 9.
// - A XOR byte at pointer pair into A; 1 byte, 4 or 5.
// - Compare subtracts without storing, updates zero, aux carry, carry.
// - All cycle counts are in selected processor clock periods.
// - Longer count when data access leaves internal high-speed RAM.
// - Shorter count for high-speed RAM or no data access.
module alus_datapath #(
    parameter HRAM_BASE = 16'hFB00,
    parameter HRAM_TOP = 16'hFEFF
) (
    input wire sys_clk,
    input wire rst_n,
    input wire clk_en,
    input wire start,
    input wire [2:0] op_sel,
    input wire [2:0] form_sel,
    input wire [1:0] idx_sel,
    input wire [7:0] acc_in,
    input wire [7:0] reg_in,
    input wire [7:0] reg_b,
    input wire [7:0] reg_c,
    input wire [15:0] pointer_pair,
    input wire [7:0] imm_byte,
    input wire [7:0] saddr_lo,
    input wire [15:0] absolute_address,
    input wire [7:0] mem_rdata,
    input wire zero_in,
    input wire aux_carry_in,
    input wire carry_in,
    output reg busy,
    output reg done,
    output reg [15:0] mem_addr,
    output reg mem_rd,
    output reg [7:0] result,
    output reg [1:0] dest,
    output reg zero_flag,
    output reg aux_carry_flag,
    output reg carry_flag,
    output wire [1:0] instr_len,
    output wire [3:0] instr_cycles
);

    // -----------------------------------------------------------------------
    // Helper functions
    // -----------------------------------------------------------------------
    function is_fast_ram;
        input [15:0] addr;
        begin
            is_fast_ram = (addr >= HRAM_BASE) && (addr <= HRAM_TOP);
        end
    endfunction

    // Low nibble borrow, full borrow, difference
    function [9:0] sub8;
        input [7:0] a;
        input [7:0] b;
        input cin;
        reg [4:0] lo;
        reg [8:0] full;
        begin
            lo = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
            full = {1'b0, a} - {1'b0, b} - {8'h00, cin};
            sub8 = {lo[4], full[8], full[7:0]};
        end
    endfunction

    // -----------------------------------------------------------------------
    // Decode of operand address and memory region
    // -----------------------------------------------------------------------
    localparam ST_IDLE = 2'h0;
    localparam ST_RUN = 2'h1;
    localparam ST_DONE = 2'h2;

    reg [1:0] state;
    reg [3:0] count;
    reg [2:0] op;
    reg [2:0] form;
    reg [7:0] opa;
    reg [7:0] opb;
    reg cin_hold;
    reg [15:0] next_addr;
    reg next_mem;
    reg [7:0] idx_val;

    wire uses_mem_start;
    wire slow_mem;
    wire load;
    wire last;
    wire fetch_mem;

    // -----------------------------------------------------------------------
    // Displacement, B or C added to the pointer pair
    // -----------------------------------------------------------------------
    always @* begin
        idx_val = imm_byte;
        if (idx_sel == `ALUS_IDX_B) begin
            idx_val = reg_b;
        end else if (idx_sel == `ALUS_IDX_C) begin
            idx_val = reg_c;
        end
    end

    always @* begin
        next_addr = 16'h0000;
        next_mem = 1'b0;
        case (form_sel)
            `ALUS_FM_SADDR_IMM, `ALUS_FM_A_SADDR: begin
                next_addr = {`ALUS_SADDR_PAGE, saddr_lo};
                next_mem = 1'b1;
            end
            `ALUS_FM_A_ABS: begin
                next_addr = absolute_address;
                next_mem = 1'b1;
            end
            `ALUS_FM_A_PTR: begin
                next_addr = pointer_pair;
                next_mem = 1'b1;
            end
            `ALUS_FM_A_PTR_IDX: begin
                next_addr = pointer_pair + {8'h00, idx_val};
                next_mem = 1'b1;
            end
            default: begin
                next_addr = 16'h0000;
                next_mem = 1'b0;
            end
        endcase
    end

    assign uses_mem_start = next_mem;
    assign slow_mem = next_mem && !is_fast_ram(next_addr);
    assign load = start && (state == ST_IDLE);
    assign last = (state == ST_RUN) && (count == instr_cycles - 4'h1);
    assign fetch_mem = (state == ST_RUN) && (count == 4'h1) && (form == `ALUS_FM_SADDR_IMM);

    alus_timing_rom u_timing (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .load(load),
        .form(form_sel),
        .slow_mem(slow_mem),
        .length(instr_len),
        .cycles(instr_cycles)
    );

    // -----------------------------------------------------------------------
    // Result computation
    // -----------------------------------------------------------------------
    reg [9:0] diff;
    reg [7:0] next_result;
    reg next_z;
    reg next_ac;
    reg next_cy;
    reg [1:0] next_dest;
    reg [7:0] src_b;

    always @* begin
        src_b = (form == `ALUS_FM_A_IMM || form == `ALUS_FM_SADDR_IMM) ? opb : mem_rdata;
        if (form == `ALUS_FM_A_REG || form == `ALUS_FM_REG_A) begin
            src_b = opb;
        end
        diff = sub8(opa, src_b, (op == `ALUS_OP_SUBC) ? cin_hold : 1'b0);
        next_z = zero_flag;
        next_ac = aux_carry_flag;
        next_cy = carry_flag;
        next_result = diff[7:0];
        // Logic operations keep aux carry and carry
        case (op)
            `ALUS_OP_OR: begin
                next_result = opa | src_b;
                next_z = (next_result == 8'h00);
            end
            `ALUS_OP_XOR: begin
                next_result = opa ^ src_b;
                next_z = (next_result == 8'h00);
            end
            default: begin
                next_result = diff[7:0];
                next_z = (diff[7:0] == 8'h00);
                next_ac = diff[9];
                next_cy = diff[8];
            end
        endcase
    end

    // -----------------------------------------------------------------------
    // Destination decode
    // -----------------------------------------------------------------------
    always @* begin
        if (op == `ALUS_OP_CMP) begin
            next_dest = `ALUS_DST_NONE;
        end else if (form == `ALUS_FM_SADDR_IMM) begin
            next_dest = `ALUS_DST_MEM;
        end else if (form == `ALUS_FM_REG_A) begin
            next_dest = `ALUS_DST_REG;
        end else begin
            next_dest = `ALUS_DST_ACC;
        end
    end

    // -----------------------------------------------------------------------
    // Sequencer: holds busy for one enabled cycle less than the documented cycle count
    // -----------------------------------------------------------------------
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            count <= 4'h0;
            busy <= 1'b0;
            done <= 1'b0;
        end else if (clk_en) begin
            done <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (start) begin
                        busy <= 1'b1;
                        count <= 4'h1;
                        state <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    // Start while busy is ignored
                    if (last) begin
                        done <= 1'b1;
                        busy <= 1'b0;
                        state <= ST_IDLE;
                    end
                    count <= count + 4'h1;
                end
                default: begin
                    // Unused code falls back to idle
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // -----------------------------------------------------------------------
    // Operand pick at start
    // -----------------------------------------------------------------------
    reg [7:0] next_opa;
    reg [7:0] next_opb;

    always @* begin
        next_opa = acc_in;
        next_opb = imm_byte;
        // Reversed register form swaps the operands
        if (form_sel == `ALUS_FM_REG_A) begin
            next_opa = reg_in;
            next_opb = acc_in;
        end else if (form_sel == `ALUS_FM_SADDR_IMM) begin
            next_opa = 8'h00; // Replaced by memory read
            next_opb = imm_byte;
        end else if (form_sel == `ALUS_FM_A_REG) begin
            next_opa = acc_in;
            next_opb = reg_in;
        end
    end

    // -----------------------------------------------------------------------
    // Operand and memory request capture
    // -----------------------------------------------------------------------
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            op <= `ALUS_OP_SUB;
            form <= `ALUS_FM_A_IMM;
            opa <= 8'h00;
            opb <= 8'h00;
            cin_hold <= 1'b0;
            mem_addr <= 16'h0000;
            mem_rd <= 1'b0;
        end else if (clk_en) begin
            mem_rd <= 1'b0;
            if (load) begin
                op <= op_sel;
                form <= form_sel;
                cin_hold <= carry_in;
                mem_addr <= next_addr;
                mem_rd <= uses_mem_start;
                opa <= next_opa;
                opb <= next_opb;
            end else if (fetch_mem) begin
                // Short-direct byte arrives the cycle after the read
                opa <= mem_rdata;
            end
        end
    end

    // -----------------------------------------------------------------------
    // Result and flag registers
    // -----------------------------------------------------------------------
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            result <= 8'h00;
            dest <= `ALUS_DST_NONE;
            zero_flag <= 1'b0;
            aux_carry_flag <= 1'b0;
            carry_flag <= 1'b0;
        end else if (clk_en) begin
            if (load) begin
                // Flags load from the inputs at start and hold until the result lands
                zero_flag <= zero_in;
                aux_carry_flag <= aux_carry_in;
                carry_flag <= carry_in;
            end else if (last) begin
                result <= next_result;
                dest <= next_dest;
                zero_flag <= next_z;
                aux_carry_flag <= next_ac;
                carry_flag <= next_cy;
            end
        end
    end

endmodule // alus_datapath

`default_nettype wire

// File: alus_datapath_sva.sv
// Port checker for the subtract, logic and compare datapath
`include "alus_defs.vh"
`default_nettype none
module alus_datapath_sva (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic start,
    input wire logic [2:0] op_sel,
    input wire logic [2:0] form_sel,
    input wire logic [7:0] acc_in,
    input wire logic [7:0] imm_byte,
    input wire logic [15:0] absolute_address,
    input wire logic busy,
    input wire logic done,
    input wire logic [15:0] mem_addr,
    input wire logic mem_rd,
    input wire logic [7:0] result,
    input wire logic [1:0] dest,
    input wire logic carry_flag,
    input wire logic [1:0] instr_len,
    input wire logic [3:0] instr_cycles
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // ------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------
    sequence s_take;
        start && !busy && !done && clk_en;
    endsequence
    sequence s_imm;
        s_take ##0 form_sel == `ALUS_FM_A_IMM;
    endsequence
    sequence s_imm_end;
        s_imm ##1 clk_en [*3];
    endsequence
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_DONE_PULSE: assert property (done && clk_en |=> !done)
        else $error("done held past one cycle");
    AST_DONE_IDLE: assert property (done |-> !busy)
        else $error("busy high with done");
    AST_TAKE_BUSY: assert property (s_take |=> busy)
        else $error("start not taken");
    AST_IMM_TIMING: assert property (s_imm |=> instr_len == 2'h2 && instr_cycles == 4'h4)
        else $error("immediate form length or cycles wrong");
    AST_PTR_LEN: assert property (s_take ##0 form_sel == `ALUS_FM_A_PTR |=>
        instr_len == 2'h1 && instr_cycles inside {4'h4, 4'h5})
        else $error("pointer form length or cycles wrong");
    AST_NO_EARLY: assert property (s_imm ##1 clk_en [*2] |=> !done)
        else $error("done too early");
    AST_IMM_DONE: assert property (s_imm_end |=> done)
        else $error("done missing after four cycles");
    AST_SUB_IMM: assert property (op_sel == `ALUS_OP_SUB ##0 s_imm_end |=>
        result == 8'($past(acc_in, 4) - $past(imm_byte, 4))
        && carry_flag == ($past(acc_in, 4) < $past(imm_byte, 4)))
        else $error("subtract result or borrow wrong");
    AST_CMP_KEEP: assert property (op_sel == `ALUS_OP_CMP ##0 s_imm_end |=>
        dest == `ALUS_DST_NONE)
        else $error("compare stored a result");
    AST_ABS_ADDR: assert property (s_take ##0 form_sel == `ALUS_FM_A_ABS |=>
        mem_rd && mem_addr == $past(absolute_address))
        else $error("absolute read address wrong");
    AST_HOLD: assert property (!done && !$past(start && !busy && clk_en) |->
        $stable(result) && $stable(carry_flag))
        else $error("result changed without done");
endmodule // alus_datapath_sva
`default_nettype wire

// File: test_alu8_subtract_logic_compare.sv
// Self-checking bench for the datapath slice
`include "alus_defs.vh"
`default_nettype none
`define CHK(g, x) begin num_checks++; if ((g) !== (x)) begin err_count++; \
    $display("Error at %0t: got %h expected %h", $time, g, x); end end
module test_alu8_subtract_logic_compare;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, start = 1'b0;
    logic [2:0] op_sel = 3'h0, form_sel = 3'h0;
    logic [1:0] idx_sel = 2'h0;
    logic [7:0] acc_in = 8'h00, reg_in = 8'h00, reg_b = 8'h00, reg_c = 8'h00;
    logic [7:0] imm_byte = 8'h00, saddr_lo = 8'h00, mem_rdata = 8'h00;
    logic [15:0] pointer_pair = 16'h0000, absolute_address = 16'h0000;
    logic zero_in = 1'b0, aux_carry_in = 1'b0, carry_in = 1'b0;
    logic busy, done, mem_rd, zero_flag, aux_carry_flag, carry_flag;
    logic [15:0] mem_addr;
    logic [7:0] result;
    logic [1:0] dest, instr_len;
    logic [3:0] instr_cycles;
    int err_count = 0, num_checks = 0;
    always #2 sys_clk = ~sys_clk;
    alus_datapath i_alus_datapath (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
        .start(start), .op_sel(op_sel), .form_sel(form_sel), .idx_sel(idx_sel),
        .acc_in(acc_in), .reg_in(reg_in), .reg_b(reg_b), .reg_c(reg_c),
        .pointer_pair(pointer_pair), .imm_byte(imm_byte), .saddr_lo(saddr_lo),
        .absolute_address(absolute_address), .mem_rdata(mem_rdata), .zero_in(zero_in),
        .aux_carry_in(aux_carry_in), .carry_in(carry_in), .busy(busy), .done(done),
        .mem_addr(mem_addr), .mem_rd(mem_rd), .result(result), .dest(dest),
        .zero_flag(zero_flag), .aux_carry_flag(aux_carry_flag), .carry_flag(carry_flag),
        .instr_len(instr_len), .instr_cycles(instr_cycles));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic conclude;
        if (err_count == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Operands packed as {acc, reg, mem, imm}; md[0] stalls, md[1] repeats start
    task automatic exec(input logic [2:0] op, input logic [2:0] fm, input logic [1:0] ix,
            input logic [31:0] v, input logic ci, input logic [15:0] ea, input logic [1:0] md);
        logic [7:0] a, r, m, im, x, y, er;
        logic [15:0] ad;
        logic [8:0] d;
        logic [4:0] h;
        logic [1:0] el, ed;
        logic [2:0] ef;
        logic [3:0] ec;
        logic memf, fast, lg, bw;
        int e, k;
        {a, r, m, im} = v;
        {x, y, ad, el, memf, ed} = {a, m, ea, 2'h2, 1'b1, `ALUS_DST_ACC};
        case (fm)
            `ALUS_FM_A_IMM: {y, memf} = {im, 1'b0};
            `ALUS_FM_SADDR_IMM: {x, y, el, ed} = {m, im, 2'h3, `ALUS_DST_MEM};
            `ALUS_FM_A_REG: {y, memf} = {r, 1'b0};
            `ALUS_FM_REG_A: {x, y, memf, ed} = {r, a, 1'b0, `ALUS_DST_REG};
            `ALUS_FM_A_ABS: el = 2'h3;
            `ALUS_FM_A_PTR: el = 2'h1;
            `ALUS_FM_A_PTR_IDX: ad = ea + {8'h00, (ix == `ALUS_IDX_DISP) ? im :
                (ix == `ALUS_IDX_B) ? r : ~r};
            default: ;
        endcase
        if (fm == `ALUS_FM_SADDR_IMM || fm == `ALUS_FM_A_SADDR) ad = {8'hFE, ea[7:0]};
        fast = !memf || (ad >= 16'hFB00 && ad <= 16'hFEFF);
        case (fm)
            `ALUS_FM_SADDR_IMM: ec = fast ? 4'h6 : 4'h8;
            `ALUS_FM_A_SADDR, `ALUS_FM_A_PTR: ec = fast ? 4'h4 : 4'h5;
            `ALUS_FM_A_ABS, `ALUS_FM_A_PTR_IDX: ec = fast ? 4'h8 : 4'h9;
            default: ec = 4'h4;
        endcase
        bw = ci & (op == `ALUS_OP_SUBC);
        d = {1'b0, x} - {1'b0, y} - {8'h00, bw};
        h = {1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, bw};
        lg = (op == `ALUS_OP_OR) || (op == `ALUS_OP_XOR);
        er = (op == `ALUS_OP_OR) ? (x | y) : (op == `ALUS_OP_XOR) ? (x ^ y) : d[7:0];
        if (op == `ALUS_OP_CMP) ed = `ALUS_DST_NONE;
        @(posedge sys_clk);
        {op_sel, form_sel, idx_sel, acc_in, reg_in, reg_b, reg_c} <= {op, fm, ix, a, r, r, ~r};
        {pointer_pair, absolute_address, saddr_lo, mem_rdata} <= {ea, ea, ea[7:0], m};
        imm_byte <= im;
        {carry_in, aux_carry_in, zero_in, start} <= {ci, ~ci, ~ci, 1'b1};
        @(posedge sys_clk);
        start <= md[1];
        clk_en <= !md[0];
        @(negedge sys_clk);
        `CHK(busy, 1'b1)
        `CHK({instr_len, instr_cycles, mem_rd}, {el, ec, memf})
        if (memf) `CHK(mem_addr, ad)
        e = 0;
        for (k = 0; k < 24 && done !== 1'b1; k++) begin
            @(posedge sys_clk);
            e += int'(clk_en);
            {start, clk_en} <= 2'b01;
            @(negedge sys_clk);
        end
        if (done !== 1'b1) begin
            err_count++;
            conclude;
        end
        `CHK(e, int'(ec) - 1)
        `CHK({busy, result, dest}, {1'b0, er, ed})
        ef = {er == 8'h00, lg ? {~ci, ci} : {h[4], d[8]}};
        `CHK({zero_flag, aux_carry_flag, carry_flag}, ef)
    endtask
    task automatic t_sub_forms;
        exec(`ALUS_OP_SUB, `ALUS_FM_A_IMM, 2'h0, 32'h10000011, 1'b0, 16'h0000, 2'h0);
        exec(`ALUS_OP_SUB, `ALUS_FM_A_REG, 2'h0, 32'h35350000, 1'b1, 16'h0000, 2'h0);
        exec(`ALUS_OP_SUB, `ALUS_FM_REG_A, 2'h0, 32'h01800000, 1'b0, 16'h0000, 2'h0);
        exec(`ALUS_OP_SUB, `ALUS_FM_SADDR_IMM, 2'h0, 32'h00000001, 1'b0, 16'h0040, 2'h0);
        exec(`ALUS_OP_SUB, `ALUS_FM_A_ABS, 2'h0, 32'h50002A00, 1'b0, 16'h1234, 2'h0);
        exec(`ALUS_OP_SUB, `ALUS_FM_A_ABS, 2'h0, 32'h50002A00, 1'b1, 16'hFB00, 2'h0);
        exec(`ALUS_OP_SUB, `ALUS_FM_A_PTR, 2'h0, 32'h0F001000, 1'b0, 16'hFEFF, 2'h0);
        exec(`ALUS_OP_SUB, `ALUS_FM_A_PTR, 2'h0, 32'h0F001000, 1'b1, 16'hFF00, 2'h0);
        exec(`ALUS_OP_SUB, `ALUS_FM_A_PTR_IDX, `ALUS_IDX_DISP, 32'h80000101, 1'b0, 16'hFEFF,
            2'h0);
        exec(`ALUS_OP_SUB, `ALUS_FM_A_PTR_IDX, `ALUS_IDX_B, 32'h80100100, 1'b0, 16'hFAF0,
            2'h0);
        exec(`ALUS_OP_SUB, `ALUS_FM_A_PTR_IDX, `ALUS_IDX_C, 32'h80EF0900, 1'b1, 16'hFEF0,
            2'h0);
    endtask
    task automatic t_subc_logic;
        exec(`ALUS_OP_SUBC, `ALUS_FM_A_IMM, 2'h0, 32'h000000FF, 1'b1, 16'h0000, 2'h0);
        exec(`ALUS_OP_SUBC, `ALUS_FM_A_IMM, 2'h0, 32'h20000010, 1'b0, 16'h0000, 2'h0);
        exec(`ALUS_OP_SUBC, `ALUS_FM_SADDR_IMM, 2'h0, 32'h00001808, 1'b1, 16'h00C0, 2'h0);
        exec(`ALUS_OP_OR, `ALUS_FM_A_IMM, 2'h0, 32'h00000000, 1'b1, 16'h0000, 2'h0);
        exec(`ALUS_OP_OR, `ALUS_FM_SADDR_IMM, 2'h0, 32'h0000A005, 1'b0, 16'h0010, 2'h0);
        exec(`ALUS_OP_OR, `ALUS_FM_A_REG, 2'h0, 32'h01020000, 1'b1, 16'h0000, 2'h0);
        exec(`ALUS_OP_OR, `ALUS_FM_REG_A, 2'h0, 32'h40040000, 1'b0, 16'h0000, 2'h0);
        exec(`ALUS_OP_OR, `ALUS_FM_A_PTR_IDX, 2'h0, 32'h0F00F002, 1'b1, 16'hFB00, 2'h0);
        exec(`ALUS_OP_XOR, `ALUS_FM_SADDR_IMM, 2'h0, 32'h00005A5A, 1'b1, 16'h0080, 2'h0);
        exec(`ALUS_OP_XOR, `ALUS_FM_A_ABS, 2'h0, 32'hFF00F000, 1'b0, 16'h8000, 2'h0);
        exec(`ALUS_OP_XOR, `ALUS_FM_A_PTR, 2'h0, 32'h3300CC00, 1'b1, 16'hFC00, 2'h0);
    endtask
    task automatic t_cmp_stall;
        for (int f = 0; f < 8; f++)
            exec(`ALUS_OP_CMP, 3'(f), `ALUS_IDX_B, 32'h42814200, 1'b1, 16'h2000, 2'h0);
        exec(`ALUS_OP_SUB, `ALUS_FM_A_IMM, 2'h0, 32'h80000001, 1'b0, 16'h0000, 2'h1);
        exec(`ALUS_OP_SUB, `ALUS_FM_A_ABS, 2'h0, 32'h7F008000, 1'b1, 16'h4000, 2'h2);
    endtask
    initial begin
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_sub_forms;
        t_subc_logic;
        t_cmp_stall;
        conclude;
    end
endmodule // test_alu8_subtract_logic_compare
bind alus_datapath alus_datapath_sva i_alus_datapath_sva (.sys_clk(sys_clk), .rst_n(rst_n),
    .clk_en(clk_en), .start(start), .op_sel(op_sel), .form_sel(form_sel), .acc_in(acc_in),
    .imm_byte(imm_byte), .absolute_address(absolute_address), .busy(busy), .done(done),
    .mem_addr(mem_addr), .mem_rd(mem_rd), .result(result), .dest(dest),
    .carry_flag(carry_flag), .instr_len(instr_len), .instr_cycles(instr_cycles));
`default_nettype wire
